// ---- hw/tpsr_regs.svh ----
`ifndef TPSR_REGS_SVH
`define TPSR_REGS_SVH

// ********************************************************
// register addresses and reset values
// ********************************************************
`define TPSR_ADDR_THRESHOLD      8'h1b
`define TPSR_ADDR_PROFILE        8'h1c
`define TPSR_ADDR_STATUS         8'h1d
`define TPSR_RST_THRESHOLD       8'h25
`define TPSR_RST_PROFILE         8'h3f
`define TPSR_RST_STATUS          8'h00
`define TPSR_UNMAPPED_DATA       8'h00

// ********************************************************
// threshold control fields
// ********************************************************
`define TPSR_COLD_SEL_MSB        7
`define TPSR_COLD_SEL_LSB        5
`define TPSR_HOT_SEL_MSB         4
`define TPSR_HOT_SEL_LSB         2
`define TPSR_WARM_V_MSB          1
`define TPSR_WARM_V_LSB          0
`define TPSR_COLD_SEL_RST        3'h1
`define TPSR_HOT_SEL_RST         3'h1
`define TPSR_WARM_V_RST          2'h1

// ********************************************************
// zone profile control fields
// ********************************************************
`define TPSR_PROF_RSVD_BIT       7
`define TPSR_MIRROR_BIT          6
`define TPSR_PREWARM_V_MSB       5
`define TPSR_PREWARM_V_LSB       4
`define TPSR_PREWARM_I_MSB       3
`define TPSR_PREWARM_I_LSB       2
`define TPSR_PRECOOL_I_MSB       1
`define TPSR_PRECOOL_I_LSB       0
`define TPSR_MIRROR_RST          1'h0
`define TPSR_PREWARM_V_RST       2'h3
`define TPSR_PREWARM_I_RST       2'h3
`define TPSR_PRECOOL_I_RST       2'h3

// ********************************************************
// encodings of offset and scale codes
// ********************************************************
`define TPSR_STEP_MV             9'h064
`define TPSR_CODE_UNCHANGED      2'h3
`define TPSR_PCT_SUSPEND         7'h00
`define TPSR_PCT_LOW             7'h14
`define TPSR_PCT_MID             7'h28
`define TPSR_PCT_FULL            7'h64

`endif

// ---- hw/tpsr_pkg.sv ----
package tpsr_pkg;

    // thermistor zone as reported by the zone comparators
    typedef enum logic [2:0] {
        ZONE_NORMAL,
        ZONE_COLD,
        ZONE_HOT,
        ZONE_COOL,
        ZONE_WARM,
        ZONE_PRECOOL,
        ZONE_PREWARM,
        ZONE_BIAS_FAULT
    } tpsr_zone_type;

    // live conditions from the charger core
    typedef struct packed {
        logic adcOneShotMode;
        logic adcConversionDone;
        logic dieThermalRegulation;
        logic forwardMode;
        logic boostOutputMode;
        logic backupMode;
        logic batteryBelowMinSystem;
        logic systemRegulationActive;
        logic inputCurrentRegulation;
        logic currentLimitPin;
        logic boostCurrentLimit;
        logic inputVoltageRegulation;
        logic boostVoltageTarget;
        logic chargeTimerExpired;
        logic watchdogExpired;
    } tpsr_cond_type;

    typedef struct packed {
        logic [2:0] coldSideThresholdSelect;
        logic [2:0] hotSideThresholdSelect;
        logic [1:0] warmZoneVoltageOffset;
        logic       coolMirrorsWarmVoltage;
        logic [1:0] prewarmVoltageOffset;
        logic [1:0] prewarmCurrentScale;
        logic [1:0] precoolCurrentScale;
    } tpsr_profile_type;

    // order matches status bits 6 down to 0
    typedef struct packed {
        logic adcDoneStatus;
        logic thermalRegulationStatus;
        logic minSystemRegulationStatus;
        logic inputCurrentLimitStatus;
        logic inputVoltageLimitStatus;
        logic chargeTimerExpiredStatus;
        logic watchdogExpiredStatus;
    } tpsr_status_type;

    typedef struct packed {
        logic [8:0] voltageDropMv;
        logic [6:0] currentPercent;
        logic       chargeSuspend;
    } tpsr_target_type;

endpackage : tpsr_pkg

// ---- hw/tpsr_status_sampler.sv ----
`timescale 1ns/1ps
module tpsr_status_sampler (
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire tpsr_pkg::tpsr_cond_type  cond,
    output tpsr_pkg::tpsr_status_type     status
);
    import tpsr_pkg::*;

    tpsr_status_type next_status;

    always_comb begin
        next_status.adcDoneStatus             = cond.adcOneShotMode & cond.adcConversionDone; // RQ10
        next_status.thermalRegulationStatus   = cond.dieThermalRegulation; // RQ11
        next_status.minSystemRegulationStatus = cond.forwardMode & cond.batteryBelowMinSystem
                                              & cond.systemRegulationActive; // RQ12
        next_status.inputCurrentLimitStatus   = (cond.forwardMode & (cond.inputCurrentRegulation
                                              | cond.currentLimitPin))
                                              | (cond.boostOutputMode & cond.boostCurrentLimit); // RQ13
        next_status.inputVoltageLimitStatus   = (cond.forwardMode & cond.inputVoltageRegulation)
                                              | ((cond.boostOutputMode | cond.backupMode)
                                              & cond.boostVoltageTarget); // RQ14
        next_status.chargeTimerExpiredStatus  = cond.chargeTimerExpired; // RQ15
        next_status.watchdogExpiredStatus     = cond.watchdogExpired; // RQ16
    end

    // plain sample every cycle, nothing latched here
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status <= '0; // RQ17
        end else begin
            status <= next_status; // RQ18
        end
    end

endmodule : tpsr_status_sampler

// ---- hw/tpsr_zone_decode.sv ----
`timescale 1ns/1ps
`include "tpsr_regs.svh"
module tpsr_zone_decode (
    input  wire logic                       mclk,
    input  wire logic                       nrst,
    input  wire tpsr_pkg::tpsr_profile_type profile,
    input  wire tpsr_pkg::tpsr_zone_type    zone,
    input  wire logic [1:0]                 warmCurrentScale,
    input  wire logic [1:0]                 coolCurrentScale,
    output tpsr_pkg::tpsr_target_type       target
);
    import tpsr_pkg::*;

    logic [1:0]      voltCode;
    logic [1:0]      currCode;
    tpsr_target_type next_target;

    // code 0..3 maps to a drop of 300..0 mV
    function automatic logic [8:0] drop_mv(input logic [1:0] code);
        logic [8:0] steps;
        steps   = {7'h00, `TPSR_CODE_UNCHANGED - code};
        drop_mv = 9'(steps * `TPSR_STEP_MV);
    endfunction : drop_mv

    function automatic logic [6:0] scale_pct(input logic [1:0] code);
        logic [6:0] pct;
        case (code)
            2'h0:    pct = `TPSR_PCT_SUSPEND;
            2'h1:    pct = `TPSR_PCT_LOW;
            2'h2:    pct = `TPSR_PCT_MID;
            default: pct = `TPSR_PCT_FULL;
        endcase
        scale_pct = pct;
    endfunction : scale_pct

    always_comb begin
        voltCode = `TPSR_CODE_UNCHANGED;
        currCode = `TPSR_CODE_UNCHANGED;
        case (zone)
            ZONE_WARM: begin
                voltCode = profile.warmZoneVoltageOffset; // RQ3
                currCode = warmCurrentScale;
            end
            ZONE_PREWARM: begin
                voltCode = profile.prewarmVoltageOffset; // RQ6
                currCode = profile.prewarmCurrentScale; // RQ7
            end
            ZONE_COOL: begin
                if (profile.coolMirrorsWarmVoltage) begin
                    voltCode = profile.warmZoneVoltageOffset; // RQ5
                end
                currCode = coolCurrentScale;
            end
            ZONE_PRECOOL: begin
                if (profile.coolMirrorsWarmVoltage) begin
                    voltCode = profile.prewarmVoltageOffset; // RQ5
                end
                currCode = profile.precoolCurrentScale; // RQ8
            end
            default: begin
                voltCode = `TPSR_CODE_UNCHANGED;
            end
        endcase
        next_target.voltageDropMv  = drop_mv(voltCode);
        next_target.currentPercent = scale_pct(currCode);
        next_target.chargeSuspend  = (currCode == 2'h0);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            target <= '0;
        end else begin
            target <= next_target;
        end
    end

endmodule : tpsr_zone_decode

// ---- hw/tpsr_regbank.sv ----
`timescale 1ns/1ps
`include "tpsr_regs.svh"
// Function
// [RQ1] cold/cool threshold selector in bits 7:5, resets to code 1
// [RQ2] warm/hot threshold selector in bits 4:2, resets to code 1
// [RQ3] warm voltage field bits 1:0: drop 300/200/100/0 mV, resets to 1
// [RQ4] threshold register at 0x1b reads 0x25 after reset and reset command
// [RQ5] mirror bit 6 makes precool/cool take prewarm/warm voltage settings
// [RQ6] prewarm voltage field bits 5:4, same encoding, resets to 3
// [RQ7] prewarm current field bits 3:2: suspend, 20%, 40%, unchanged
// [RQ8] precool current field bits 1:0, same encoding, resets to unchanged
// [RQ9] profile register at 0x1c reads 0x3f; bit 7 reads zero, read-only
// [RQ10] status bit 6 shows one-shot conversion done, zero in continuous mode
// [RQ11] status bit 5 shows die thermal regulation
// [RQ12] status bit 4 shows minimum-system regulation in forward mode
// [RQ13] status bit 3 shows input or boost current limiting
// [RQ14] status bit 2 shows input or boost/backup voltage regulation
// [RQ15] status bit 1 shows safety timer expired
// [RQ16] status bit 0 shows watchdog expired
// [RQ17] status register at 0x1d is read-only, resets 0x00, bit 7 reserved
// [RQ18] status bits are live and never cleared by a read
module tpsr_regbank (
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    input  wire logic [7:0]              regAddr,
    input  wire logic                    regWrite,
    input  wire logic                    regRead,
    input  wire logic [7:0]              regWdata,
    input  wire logic                    regResetCmd,
    input  wire tpsr_pkg::tpsr_cond_type cond,
    input  wire tpsr_pkg::tpsr_zone_type zone,
    input  wire logic [1:0]              warmCurrentScale,
    input  wire logic [1:0]              coolCurrentScale,
    output logic                         regHit,
    output logic [7:0]                   regRdata,
    output tpsr_pkg::tpsr_profile_type   profile,
    output tpsr_pkg::tpsr_status_type    status,
    output tpsr_pkg::tpsr_target_type    target
);
    import tpsr_pkg::*;

    // ********************************************************
    // address decode
    // ********************************************************
    logic hitThreshold;
    logic hitProfile;
    logic hitStatus;
    logic wrThreshold;
    logic wrProfile;

    assign hitThreshold = (regAddr == `TPSR_ADDR_THRESHOLD);
    assign hitProfile   = (regAddr == `TPSR_ADDR_PROFILE);
    assign hitStatus    = (regAddr == `TPSR_ADDR_STATUS);
    assign regHit       = hitThreshold | hitProfile | hitStatus;

    // the reset command outranks a write in the same cycle
    assign wrThreshold  = regWrite & hitThreshold & ~regResetCmd;
    assign wrProfile    = regWrite & hitProfile & ~regResetCmd;

    // ********************************************************
    // threshold control register fields
    // ********************************************************
    logic [2:0] coldSideThresholdSelect;
    logic [2:0] hotSideThresholdSelect;
    logic [1:0] warmZoneVoltageOffset;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            coldSideThresholdSelect <= `TPSR_COLD_SEL_RST; // RQ1
        end else if (regResetCmd) begin
            coldSideThresholdSelect <= `TPSR_COLD_SEL_RST; // RQ4
        end else if (wrThreshold) begin
            coldSideThresholdSelect <= regWdata[`TPSR_COLD_SEL_MSB:`TPSR_COLD_SEL_LSB]; // RQ1
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hotSideThresholdSelect <= `TPSR_HOT_SEL_RST; // RQ2
        end else if (regResetCmd) begin
            hotSideThresholdSelect <= `TPSR_HOT_SEL_RST; // RQ4
        end else if (wrThreshold) begin
            hotSideThresholdSelect <= regWdata[`TPSR_HOT_SEL_MSB:`TPSR_HOT_SEL_LSB]; // RQ2
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            warmZoneVoltageOffset <= `TPSR_WARM_V_RST; // RQ3
        end else if (regResetCmd) begin
            warmZoneVoltageOffset <= `TPSR_WARM_V_RST; // RQ4
        end else if (wrThreshold) begin
            warmZoneVoltageOffset <= regWdata[`TPSR_WARM_V_MSB:`TPSR_WARM_V_LSB]; // RQ3
        end
    end

    // ********************************************************
    // zone profile register fields
    // ********************************************************
    logic       coolMirrorsWarmVoltage;
    logic [1:0] prewarmVoltageOffset;
    logic [1:0] prewarmCurrentScale;
    logic [1:0] precoolCurrentScale;

    // bit 7 has no storage, so writes to it simply vanish
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            coolMirrorsWarmVoltage <= `TPSR_MIRROR_RST;
        end else if (regResetCmd) begin
            coolMirrorsWarmVoltage <= `TPSR_MIRROR_RST; // RQ9
        end else if (wrProfile) begin
            coolMirrorsWarmVoltage <= regWdata[`TPSR_MIRROR_BIT]; // RQ5
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prewarmVoltageOffset <= `TPSR_PREWARM_V_RST; // RQ6
        end else if (regResetCmd) begin
            prewarmVoltageOffset <= `TPSR_PREWARM_V_RST; // RQ9
        end else if (wrProfile) begin
            prewarmVoltageOffset <= regWdata[`TPSR_PREWARM_V_MSB:`TPSR_PREWARM_V_LSB]; // RQ6
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prewarmCurrentScale <= `TPSR_PREWARM_I_RST; // RQ7
        end else if (regResetCmd) begin
            prewarmCurrentScale <= `TPSR_PREWARM_I_RST; // RQ9
        end else if (wrProfile) begin
            prewarmCurrentScale <= regWdata[`TPSR_PREWARM_I_MSB:`TPSR_PREWARM_I_LSB]; // RQ7
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            precoolCurrentScale <= `TPSR_PRECOOL_I_RST; // RQ8
        end else if (regResetCmd) begin
            precoolCurrentScale <= `TPSR_PRECOOL_I_RST; // RQ9
        end else if (wrProfile) begin
            precoolCurrentScale <= regWdata[`TPSR_PRECOOL_I_MSB:`TPSR_PRECOOL_I_LSB]; // RQ8
        end
    end

    // ********************************************************
    // register images
    // ********************************************************
    logic [7:0] thresholdImage;
    logic [7:0] profileImage;
    logic [7:0] statusImage;

    always_comb begin
        thresholdImage = '0;
        thresholdImage[`TPSR_COLD_SEL_MSB:`TPSR_COLD_SEL_LSB] = coldSideThresholdSelect;
        thresholdImage[`TPSR_HOT_SEL_MSB:`TPSR_HOT_SEL_LSB]   = hotSideThresholdSelect;
        thresholdImage[`TPSR_WARM_V_MSB:`TPSR_WARM_V_LSB]     = warmZoneVoltageOffset;
    end

    always_comb begin
        profileImage = '0;
        profileImage[`TPSR_PROF_RSVD_BIT] = 1'h0; // RQ9
        profileImage[`TPSR_MIRROR_BIT]    = coolMirrorsWarmVoltage;
        profileImage[`TPSR_PREWARM_V_MSB:`TPSR_PREWARM_V_LSB] = prewarmVoltageOffset;
        profileImage[`TPSR_PREWARM_I_MSB:`TPSR_PREWARM_I_LSB] = prewarmCurrentScale;
        profileImage[`TPSR_PRECOOL_I_MSB:`TPSR_PRECOOL_I_LSB] = precoolCurrentScale;
    end

    // reserved top bit of the status word is tied low
    assign statusImage = {1'h0, status}; // RQ17

    // ********************************************************
    // live status
    // ********************************************************
    // conditions are sampled every cycle; no read side effect
    tpsr_status_sampler tpsr_status_sampler_inst (
        .mclk   (mclk),
        .nrst   (nrst),
        .cond   (cond),
        .status (status)
    );

    // ********************************************************
    // read path
    // ********************************************************
    logic [7:0] next_regRdata;

    // reads have no side effect on any bit
    always_comb begin
        next_regRdata = `TPSR_UNMAPPED_DATA;
        if (hitThreshold) begin
            next_regRdata = thresholdImage; // RQ4
        end else if (hitProfile) begin
            next_regRdata = profileImage; // RQ9
        end else if (hitStatus) begin
            next_regRdata = statusImage; // RQ18
        end
    end

    // read data holds until the next read, so a slow serial engine
    // can shift it out at leisure
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= `TPSR_UNMAPPED_DATA;
        end else if (regRead) begin
            regRdata <= next_regRdata;
        end
    end

    // ********************************************************
    // profile outputs to the threshold and regulation logic
    // ********************************************************
    always_comb begin
        profile.coldSideThresholdSelect = coldSideThresholdSelect; // RQ1
        profile.hotSideThresholdSelect  = hotSideThresholdSelect; // RQ2
        profile.warmZoneVoltageOffset   = warmZoneVoltageOffset;
        profile.coolMirrorsWarmVoltage  = coolMirrorsWarmVoltage;
        profile.prewarmVoltageOffset    = prewarmVoltageOffset;
        profile.prewarmCurrentScale     = prewarmCurrentScale;
        profile.precoolCurrentScale     = precoolCurrentScale;
    end

    // ********************************************************
    // per-zone charge targets
    // ********************************************************
    // one cycle of latency here is harmless against analog loop rates
    tpsr_zone_decode tpsr_zone_decode_inst (
        .mclk             (mclk),
        .nrst             (nrst),
        .profile          (profile),
        .zone             (zone),
        .warmCurrentScale (warmCurrentScale),
        .coolCurrentScale (coolCurrentScale),
        .target           (target)
    );

endmodule : tpsr_regbank

// ---- bench/tpsr_regbank_sva.sv ----
`timescale 1ns/1ps
module tpsr_regbank_sva (
    input wire logic                       mclk,
    input wire logic                       nrst,
    input wire logic [7:0]                 regAddr,
    input wire logic                       regWrite,
    input wire logic                       regRead,
    input wire logic [7:0]                 regWdata,
    input wire logic                       regResetCmd,
    input wire tpsr_pkg::tpsr_cond_type    cond,
    input wire tpsr_pkg::tpsr_zone_type    zone,
    input wire logic                       regHit,
    input wire logic [7:0]                 regRdata,
    input wire tpsr_pkg::tpsr_profile_type profile,
    input wire tpsr_pkg::tpsr_status_type  status,
    input wire tpsr_pkg::tpsr_target_type  target
);
    import tpsr_pkg::*;
    // **********
    // register port, live status and warm zone target checks
    // **********
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_hit;
        regHit == (regAddr inside {8'h1b, 8'h1c, 8'h1d});
    endproperty
    a_hit: assert property (p_hit)
        else $error("address decode mismatch");
    // read returns the image from before any same-cycle write
    property p_rd_thr;
        regRead && regAddr == 8'h1b |=> regRdata == $past(profile[14:7]);
    endproperty
    a_rd_thr: assert property (p_rd_thr)
        else $error("threshold read image wrong");
    property p_rd_prof;
        regRead && regAddr == 8'h1c |=> regRdata == {1'h0, $past(profile[6:0])};
    endproperty
    a_rd_prof: assert property (p_rd_prof)
        else $error("profile read image wrong");
    property p_rd_stat;
        regRead && regAddr == 8'h1d |=> regRdata == {1'h0, $past(status)};
    endproperty
    a_rd_stat: assert property (p_rd_stat)
        else $error("status read image wrong");
    property p_rd_none;
        regRead && !regHit |=> regRdata == 8'h00;
    endproperty
    a_rd_none: assert property (p_rd_none)
        else $error("unmapped read not zero");
    property p_wr_thr;
        regWrite && !regResetCmd && regAddr == 8'h1b |=> profile[14:7] == $past(regWdata);
    endproperty
    a_wr_thr: assert property (p_wr_thr)
        else $error("threshold write lost");
    property p_wr_prof;
        regWrite && !regResetCmd && regAddr == 8'h1c
            |=> profile[6:0] == $past(regWdata[6:0]);
    endproperty
    a_wr_prof: assert property (p_wr_prof)
        else $error("profile write lost");
    property p_rst_cmd;
        regResetCmd ##1 !regWrite
            |-> profile == {8'h25, 7'h3f} ##1 profile == {8'h25, 7'h3f};
    endproperty
    a_rst_cmd: assert property (p_rst_cmd)
        else $error("reset command left a field");
    property p_adc;
        $past(nrst) |-> status.adcDoneStatus
            == $past(cond.adcConversionDone && cond.adcOneShotMode);
    endproperty
    a_adc: assert property (p_adc)
        else $error("conversion done status wrong");
    property p_cur;
        $past(nrst) |-> status.inputCurrentLimitStatus == $past(
            (cond.forwardMode && (cond.inputCurrentRegulation || cond.currentLimitPin))
            || (cond.boostOutputMode && cond.boostCurrentLimit));
    endproperty
    a_cur: assert property (p_cur)
        else $error("current limit status wrong");
    property p_wd;
        $past(nrst) |-> status.watchdogExpiredStatus == $past(cond.watchdogExpired);
    endproperty
    a_wd: assert property (p_wd)
        else $error("watchdog status wrong");
    property p_warm_v;
        zone == ZONE_WARM |=> target.voltageDropMv
            == {7'h00, ~$past(profile.warmZoneVoltageOffset)} * 9'h064;
    endproperty
    a_warm_v: assert property (p_warm_v)
        else $error("warm voltage drop wrong");
endmodule : tpsr_regbank_sva

// ---- bench/tpsr_host_model.sv ----
`timescale 1ns/1ps
module tpsr_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] regRdata,
    output logic [7:0]      regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic [7:0]      regWdata,
    output logic            regResetCmd
);
    initial begin
        regAddr = 8'h00;
        regWrite = 1'h0;
        regRead = 1'h0;
        regWdata = 8'h00;
        regResetCmd = 1'h0;
    end
    // data goes inverted once released so stale values never pass
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge mclk);
        regWrite <= 1'h0;
        regWdata <= ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge mclk);
        regRead <= 1'h0;
        @(negedge mclk);
        d = regRdata;
    endtask : read_reg
    task automatic reset_cmd();
        @(posedge mclk);
        regResetCmd <= 1'h1;
        @(posedge mclk);
        regResetCmd <= 1'h0;
    endtask : reset_cmd
endmodule : tpsr_host_model

// ---- bench/tpsr_regbank_tb.sv ----
`timescale 1ns/1ps
module tpsr_regbank_tb;
    import tpsr_pkg::*;
    logic             mclk = 1'h0;
    logic             nrst = 1'h0;
    logic             regWrite, regRead, regResetCmd, regHit;
    logic [7:0]       regAddr, regWdata, regRdata;
    logic [1:0]       warmCurrentScale = 2'h2;
    logic [1:0]       coolCurrentScale = 2'h1;
    tpsr_cond_type    cond = '0;
    tpsr_zone_type    zone = ZONE_NORMAL;
    tpsr_profile_type profile;
    tpsr_status_type  status;
    tpsr_target_type  target;
    int               errors = 0;
    int               nChecks = 0;
    // **********
    // stimulus tables
    // **********
    tpsr_cond_type    condTab [11] = '{15'h6000, 15'h2000, 15'h1000, 15'h0980, 15'h0820,
                                       15'h0410, 15'h0204, 15'h0808, 15'h0002, 15'h0001,
                                       15'h0840};
    logic [7:0]       statTab [11] = '{8'h40, 8'h00, 8'h20, 8'h10, 8'h08,
                                       8'h08, 8'h04, 8'h04, 8'h02, 8'h01, 8'h08};
    tpsr_zone_type    zoneTab [7] = '{ZONE_WARM, ZONE_PREWARM, ZONE_COOL, ZONE_PRECOOL,
                                      ZONE_NORMAL, ZONE_COOL, ZONE_PRECOOL};
    logic [7:0]       profTab [7] = '{8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h24, 8'h24};
    tpsr_target_type  tgtTab [7] = '{{9'h12c, 7'h28, 1'h0}, {9'h064, 7'h14, 1'h0},
                                     {9'h12c, 7'h14, 1'h0}, {9'h064, 7'h00, 1'h1},
                                     {9'h000, 7'h64, 1'h0}, {9'h000, 7'h14, 1'h0},
                                     {9'h000, 7'h00, 1'h1}};

    always #2 mclk = ~mclk;

    tpsr_host_model tpsr_host_model_inst (.mclk(mclk), .regRdata(regRdata),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regResetCmd(regResetCmd));
    tpsr_regbank tpsr_regbank_inst (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regResetCmd(regResetCmd), .cond(cond), .zone(zone),
        .warmCurrentScale(warmCurrentScale), .coolCurrentScale(coolCurrentScale),
        .regHit(regHit), .regRdata(regRdata), .profile(profile), .status(status),
        .target(target));

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check8
    task automatic check_tgt(input tpsr_target_type exp, input tpsr_target_type got);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value target expected %h seen %h", exp, got);
        end
    endtask : check_tgt
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        tpsr_host_model_inst.read_reg(a, d);
        check8($sformatf("reg %h", a), exp, d);
    endtask : rd_chk
    task automatic conclude();
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // guard against a hung sequence
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'h1;
        rd_chk(8'h1b, 8'h25);
        rd_chk(8'h1c, 8'h3f);
        rd_chk(8'h1d, 8'h00);
        $display("test reset values done");
        tpsr_host_model_inst.write_reg(8'h1b, 8'hff);
        tpsr_host_model_inst.write_reg(8'h1c, 8'hff);
        tpsr_host_model_inst.write_reg(8'h1d, 8'hff);
        tpsr_host_model_inst.write_reg(8'h1e, 8'hff);
        rd_chk(8'h1b, 8'hff);
        rd_chk(8'h1c, 8'h7f);
        rd_chk(8'h1d, 8'h00);
        rd_chk(8'h1e, 8'h00);
        tpsr_host_model_inst.reset_cmd();
        rd_chk(8'h1b, 8'h25);
        rd_chk(8'h1c, 8'h3f);
        $display("test access and reset command done");
        for (int i = 0; i < 11; i++) begin
            @(posedge mclk);
            cond <= condTab[i];
            rd_chk(8'h1d, statTab[i]);
            rd_chk(8'h1d, statTab[i]);
        end
        $display("test live status done");
        tpsr_host_model_inst.write_reg(8'h1b, 8'h24);
        for (int i = 0; i < 7; i++) begin
            tpsr_host_model_inst.write_reg(8'h1c, profTab[i]);
            zone <= zoneTab[i];
            @(posedge mclk);
            @(posedge mclk);
            @(negedge mclk);
            check_tgt(tgtTab[i], target);
        end
        $display("test zone targets done");
        conclude();
    end
endmodule : tpsr_regbank_tb

bind tpsr_regbank tpsr_regbank_sva tpsr_regbank_sva_inst (.mclk(mclk), .nrst(nrst),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regResetCmd(regResetCmd), .cond(cond), .zone(zone), .regHit(regHit),
    .regRdata(regRdata), .profile(profile), .status(status), .target(target));
